// ===== shared/rl_defs.vh
// Register map, field layout and timing constants of the port B rate limiter
`ifndef RL_DEFS_VH
`define RL_DEFS_VH

// Register offsets
`define RL_OFF_CTRL3        8'h8A
`define RL_OFF_ING_LOW      8'h8C
`define RL_OFF_ING_HIGH     8'h8E
`define RL_OFF_EGR_LOW      8'h90
`define RL_OFF_EGR_HIGH     8'h92
`define RL_OFF_POLICY       8'hA0
`define RL_OFF_STATUS       8'hA2
`define RL_OFF_ING_LIMITED  8'hA4
`define RL_OFF_EGR_LIMITED  8'hA6

// Control three fields
`define RL_CTRL3_PRE_BIT    0
`define RL_CTRL3_IFG_BIT    1
`define RL_CTRL3_MODE_LSB   2
`define RL_CTRL3_MODE_MSB   3
`define RL_CTRL3_SPARE_BIT  4
`define RL_CTRL3_RW_MASK    16'h001F

// Rate register fields
`define RL_RATE_LO_LSB      0
`define RL_RATE_HI_LSB      8
`define RL_RATE_MASK        16'h7F7F
`define RL_EGR_EN_BIT       7
`define RL_EGR_LOW_MASK     16'h7FFF

// Policy fields
`define RL_POL_ING_DROP_BIT 0
`define RL_POL_EGR_DROP_BIT 1
`define RL_POL_MASK         16'h0003

// Reset values
`define RL_RST_CTRL3        16'h0000
`define RL_RST_RATE         16'h0000
`define RL_RST_POLICY       16'h0000

// Ingress limit modes
`define RL_MODE_ALL         2'h0
`define RL_MODE_FLOOD       2'h1
`define RL_MODE_MCAST       2'h2
`define RL_MODE_BCAST       2'h3

// Frame kinds
`define RL_KIND_UCAST       2'h0
`define RL_KIND_FLOOD       2'h1
`define RL_KIND_MCAST       2'h2
`define RL_KIND_BCAST       2'h3

// Per-frame allowances in bytes
`define RL_IFG_BYTES        12'h00C
`define RL_PRE_BYTES        12'h008

// Rate table: code c from 1 up refills c bytes per tick, code 0 keeps the bucket full, codes above the top saturate
`define RL_CODE_NONE        7'h00
`define RL_CODE_TOP         7'h64
`define RL_BUCKET_CAP       16'h1000
`define RL_CREDIT_LOW       16'h0600

// Refill tick timing
`define RL_CLK_NS           20
`define RL_TICK_FAST_NS     8000
`define RL_TICK_SLOW_NS     80000
`define RL_TICK_FAST_CYC    (`RL_TICK_FAST_NS / `RL_CLK_NS)
`define RL_TICK_SLOW_CYC    (`RL_TICK_SLOW_NS / `RL_CLK_NS)
// Last count of each refill period, sized for the tick counter
`define RL_TICK_FAST_LAST   12'h18F
`define RL_TICK_SLOW_LAST   12'hF9F

`endif

// ===== logic/rl_charge.v
// Charged frame length with optional gap and preamble allowances
`timescale 1ns/1ns
`include "rl_defs.vh"

module rl_charge (
  // Frame
  input  wire [10:0] frame_len,
  // Options
  input  wire        ifg_en,
  input  wire        pre_en,
  // Result
  output wire [11:0] charge_len
);

  wire [11:0] ifg_add;
  wire [11:0] pre_add;

  assign ifg_add    = ifg_en ? `RL_IFG_BYTES : 12'h000;
  assign pre_add    = pre_en ? `RL_PRE_BYTES : 12'h000;
  assign charge_len = {1'b0, frame_len} + ifg_add + pre_add;

endmodule

// ===== logic/rl_bucket.v
// Byte-credit accumulator for one priority class and direction
`timescale 1ns/1ns
`include "rl_defs.vh"

module rl_bucket (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Refill
  input  wire        tick,
  input  wire [6:0]  rate_code,
  // Consume
  input  wire        take,
  input  wire [11:0] take_len,
  // State
  output reg  [15:0] credit,
  output wire        enough
);

  wire [6:0]  add;
  wire [16:0] sum;
  wire [15:0] filled;
  reg  [15:0] next_credit;

  // Codes above the top of the table refill at the top code's rate
  assign add    = (rate_code > `RL_CODE_TOP) ? `RL_CODE_TOP : rate_code;
  assign sum    = {1'b0, credit} + {10'h000, add};
  assign filled = !tick ? credit :
                  (sum > {1'b0, `RL_BUCKET_CAP}) ? `RL_BUCKET_CAP : sum[15:0];
  assign enough = (credit >= {4'h0, take_len});

  always @* begin
    if (rate_code == `RL_CODE_NONE) begin
      next_credit = `RL_BUCKET_CAP;
    end else if (take) begin
      next_credit = filled - {4'h0, take_len};
    end else begin
      next_credit = filled;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      credit <= `RL_BUCKET_CAP;
    end else begin
      credit <= next_credit;
    end
  end

endmodule

// ===== logic/rl_port_limiter.v
// Port B ingress and egress rate limiter with its register file
`timescale 1ns/1ns
`include "rl_defs.vh"

module rl_port_limiter (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Link state
  input  wire        link_fast,
  // Ingress frame path
  input  wire        ing_req,
  input  wire [10:0] ing_len,
  input  wire [1:0]  ing_prio,
  input  wire [1:0]  ing_kind,
  output reg         ing_admit,
  output reg         ing_hold,
  output reg         ing_drop,
  // Egress frame path
  input  wire        egr_req,
  input  wire [10:0] egr_len,
  input  wire [1:0]  egr_prio,
  output reg         egr_admit,
  output reg         egr_hold,
  output reg         egr_drop
);

  localparam [11:0] TICK_FAST = `RL_TICK_FAST_LAST;
  localparam [11:0] TICK_SLOW = `RL_TICK_SLOW_LAST;

  // Registers
  reg  [15:0] ctrl3;
  reg  [15:0] ing_rate_low;
  reg  [15:0] ing_rate_high;
  reg  [15:0] egr_rate_low;
  reg  [15:0] egr_rate_high;
  reg  [15:0] policy;
  reg  [15:0] ing_limited;
  reg  [15:0] egr_limited;
  reg  [15:0] next_rdata;

  // Refill timing
  reg  [11:0] tick_cnt;
  reg         tick;
  wire [11:0] tick_last;
  wire        tick_wrap;

  // Per-class state, index 0-3 ingress, 4-7 egress
  wire [6:0]  code [0:7];
  wire [15:0] credit [0:7];
  wire [7:0]  enough;
  wire [7:0]  take;
  wire [7:0]  credit_low;
  wire [11:0] ing_charge;
  wire [11:0] egr_charge;

  // Decisions
  wire        ing_limit;
  wire        egr_limit;
  wire        ing_fits;
  wire        egr_fits;
  wire        ing_over;
  wire        egr_over;
  reg         next_ing_admit;
  reg         next_ing_hold;
  reg         next_ing_drop;
  reg         next_egr_admit;
  reg         next_egr_hold;
  reg         next_egr_drop;
  wire        ing_cnt_clr;
  wire        egr_cnt_clr;

  // Pick one 7-bit code out of a rate register
  function [6:0] rate_field;
    input [15:0] r;
    input        hi;
    begin
      rate_field = hi ? r[`RL_RATE_HI_LSB +: 7] : r[`RL_RATE_LO_LSB +: 7];
    end
  endfunction

  // Whether a frame kind is charged under an ingress mode
  function kind_charged;
    input [1:0] mode;
    input [1:0] kind;
    begin
      case (mode)
        `RL_MODE_ALL:   kind_charged = 1'b1;
        `RL_MODE_FLOOD: kind_charged = (kind != `RL_KIND_UCAST);
        `RL_MODE_MCAST: kind_charged = (kind == `RL_KIND_MCAST) || (kind == `RL_KIND_BCAST);
        `RL_MODE_BCAST: kind_charged = (kind == `RL_KIND_BCAST);
        default:        kind_charged = 1'b1;
      endcase
    end
  endfunction

  // Saturating event counter, a set in the clearing cycle wins
  function [15:0] count_step;
    input [15:0] cur;
    input        clr;
    input        inc;
    begin
      if (clr && inc) begin
        count_step = 16'h0001;
      end else if (clr) begin
        count_step = 16'h0000;
      end else if (inc && (cur != 16'hFFFF)) begin
        count_step = cur + 16'h0001;
      end else begin
        count_step = cur;
      end
    end
  endfunction

  assign code[0] = rate_field(ing_rate_low, 1'b0);
  assign code[1] = rate_field(ing_rate_low, 1'b1);
  assign code[2] = rate_field(ing_rate_high, 1'b0);
  assign code[3] = rate_field(ing_rate_high, 1'b1);
  assign code[4] = rate_field(egr_rate_low, 1'b0);
  assign code[5] = rate_field(egr_rate_low, 1'b1);
  assign code[6] = rate_field(egr_rate_high, 1'b0);
  assign code[7] = rate_field(egr_rate_high, 1'b1);

  // Charged lengths
  rl_charge u_ing_charge (
    .frame_len  (ing_len),
    .ifg_en     (ctrl3[`RL_CTRL3_IFG_BIT]),
    .pre_en     (ctrl3[`RL_CTRL3_PRE_BIT]),
    .charge_len (ing_charge)
  );

  rl_charge u_egr_charge (
    .frame_len  (egr_len),
    .ifg_en     (ctrl3[`RL_CTRL3_IFG_BIT]),
    .pre_en     (ctrl3[`RL_CTRL3_PRE_BIT]),
    .charge_len (egr_charge)
  );

  // Credit accumulators
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bucket
      rl_bucket u_bucket (
        .clk       (clk),
        .rst_n     (rst_n),
        .tick      (tick),
        .rate_code (code[gi]),
        .take      (take[gi]),
        .take_len  ((gi < 4) ? ing_charge : egr_charge),
        .credit    (credit[gi]),
        .enough    (enough[gi])
      );
      assign credit_low[gi] = (credit[gi] < `RL_CREDIT_LOW);
      if (gi < 4) begin : g_ing
        assign take[gi] = ing_req && ing_limit && ing_fits && (ing_prio == gi);
      end else begin : g_egr
        assign take[gi] = egr_req && egr_limit && egr_fits && (egr_prio == (gi - 4));
      end
    end
  endgenerate

  // Refill tick, period follows link speed
  assign tick_last = link_fast ? TICK_FAST : TICK_SLOW;
  assign tick_wrap = (tick_cnt >= tick_last);

  always @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt <= 12'h000;
      tick     <= 1'b0;
    end else if (tick_wrap) begin
      tick_cnt <= 12'h000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 12'h001;
      tick     <= 1'b0;
    end
  end

  // Limiting decisions
  assign ing_limit = kind_charged(ctrl3[`RL_CTRL3_MODE_MSB:`RL_CTRL3_MODE_LSB], ing_kind)
                     && (code[{1'b0, ing_prio}] != `RL_CODE_NONE);
  assign egr_limit = egr_rate_low[`RL_EGR_EN_BIT]
                     && (code[{1'b1, egr_prio}] != `RL_CODE_NONE);
  assign ing_fits  = enough[{1'b0, ing_prio}];
  assign egr_fits  = enough[{1'b1, egr_prio}];
  assign ing_over  = ing_req && ing_limit && !ing_fits;
  assign egr_over  = egr_req && egr_limit && !egr_fits;

  // Exactly one answer for each request, none without one
  always @* begin
    next_ing_admit = 1'b0;
    next_ing_hold  = 1'b0;
    next_ing_drop  = 1'b0;
    next_egr_admit = 1'b0;
    next_egr_hold  = 1'b0;
    next_egr_drop  = 1'b0;
    if (ing_over) begin
      next_ing_hold = !policy[`RL_POL_ING_DROP_BIT];
      next_ing_drop = policy[`RL_POL_ING_DROP_BIT];
    end else if (ing_req) begin
      next_ing_admit = 1'b1;
    end
    if (egr_over) begin
      next_egr_hold = !policy[`RL_POL_EGR_DROP_BIT];
      next_egr_drop = policy[`RL_POL_EGR_DROP_BIT];
    end else if (egr_req) begin
      next_egr_admit = 1'b1;
    end
  end

  // Frame answers, one cycle after the request
  always @(posedge clk) begin
    if (!rst_n) begin
      ing_admit <= 1'b0;
      ing_hold  <= 1'b0;
      ing_drop  <= 1'b0;
      egr_admit <= 1'b0;
      egr_hold  <= 1'b0;
      egr_drop  <= 1'b0;
    end else begin
      ing_admit <= next_ing_admit;
      ing_hold  <= next_ing_hold;
      ing_drop  <= next_ing_drop;
      egr_admit <= next_egr_admit;
      egr_hold  <= next_egr_hold;
      egr_drop  <= next_egr_drop;
    end
  end

  // Register writes
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl3         <= `RL_RST_CTRL3;
      ing_rate_low  <= `RL_RST_RATE;
      ing_rate_high <= `RL_RST_RATE;
      egr_rate_low  <= `RL_RST_RATE;
      egr_rate_high <= `RL_RST_RATE;
      policy        <= `RL_RST_POLICY;
    end else if (reg_wr) begin
      case (reg_addr)
        `RL_OFF_CTRL3:    ctrl3         <= reg_wdata & `RL_CTRL3_RW_MASK;
        `RL_OFF_ING_LOW:  ing_rate_low  <= reg_wdata & `RL_RATE_MASK;
        `RL_OFF_ING_HIGH: ing_rate_high <= reg_wdata & `RL_RATE_MASK;
        `RL_OFF_EGR_LOW:  egr_rate_low  <= reg_wdata & `RL_EGR_LOW_MASK;
        `RL_OFF_EGR_HIGH: egr_rate_high <= reg_wdata & `RL_RATE_MASK;
        `RL_OFF_POLICY:   policy        <= reg_wdata & `RL_POL_MASK;
        default:          policy        <= policy;
      endcase
    end
  end

  assign ing_cnt_clr = reg_wr && (reg_addr == `RL_OFF_ING_LIMITED);
  assign egr_cnt_clr = reg_wr && (reg_addr == `RL_OFF_EGR_LIMITED);

  // Limited-frame counters, cleared by any write to their offset
  always @(posedge clk) begin
    if (!rst_n) begin
      ing_limited <= 16'h0000;
      egr_limited <= 16'h0000;
    end else begin
      ing_limited <= count_step(ing_limited, ing_cnt_clr, ing_over);
      egr_limited <= count_step(egr_limited, egr_cnt_clr, egr_over);
    end
  end

  // Read mux, unmapped offsets read zero
  always @* begin
    case (reg_addr)
      `RL_OFF_CTRL3:       next_rdata = ctrl3;
      `RL_OFF_ING_LOW:     next_rdata = ing_rate_low;
      `RL_OFF_ING_HIGH:    next_rdata = ing_rate_high;
      `RL_OFF_EGR_LOW:     next_rdata = egr_rate_low;
      `RL_OFF_EGR_HIGH:    next_rdata = egr_rate_high;
      `RL_OFF_POLICY:      next_rdata = policy;
      `RL_OFF_STATUS:      next_rdata = {8'h00, credit_low};
      `RL_OFF_ING_LIMITED: next_rdata = ing_limited;
      `RL_OFF_EGR_LIMITED: next_rdata = egr_limited;
      default:             next_rdata = 16'h0000;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// ===== sim/rl_port_limiter_asserts.sv
// Assertion checker for the port B rate limiter
`timescale 1ns/1ns
module rl_port_limiter_asserts (
  // Clock and reset
  input wire        clk,
  input wire        rst_n,
  // Register port
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // Frame paths
  input wire        ing_req,
  input wire [1:0]  ing_prio,
  input wire        ing_admit,
  input wire        ing_hold,
  input wire        ing_drop,
  input wire        egr_req,
  input wire        egr_admit,
  input wire        egr_hold,
  input wire        egr_drop
);
  reg       egr_on;
  reg [6:0] code0;
  // Shadow of the egress enable and the priority 0 ingress code
  always @(posedge clk) begin
    if (!rst_n) begin
      egr_on <= 1'b0;
      code0  <= 7'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h90) egr_on <= reg_wdata[7];
      if (reg_addr == 8'h8C) code0 <= reg_wdata[6:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ing_one_answer: assert property (ing_req |=> $onehot({ing_admit, ing_hold, ing_drop}))
    else $error("ingress answer not unique");
  chk_ing_no_answer: assert property (!ing_req |=> {ing_admit, ing_hold, ing_drop} == 3'h0)
    else $error("ingress answer without request");
  chk_egr_one_answer: assert property (egr_req |=> $onehot({egr_admit, egr_hold, egr_drop}))
    else $error("egress answer not unique");
  chk_egr_no_answer: assert property (!egr_req |=> {egr_admit, egr_hold, egr_drop} == 3'h0)
    else $error("egress answer without request");
  chk_ing_rsvd_bits: assert property (reg_rd && reg_addr[7:2] == 6'h23 |=> {reg_rdata[15], reg_rdata[7]} == 2'h0)
    else $error("ingress reserved bit set");
  chk_egr_rsvd_bits: assert property (reg_rd && reg_addr == 8'h92 |=> {reg_rdata[15], reg_rdata[7]} == 2'h0)
    else $error("egress reserved bit set");
  chk_ctrl3_rsvd: assert property (reg_rd && reg_addr == 8'h8A |=> reg_rdata[15:5] == 11'h000)
    else $error("control reserved bits set");
  chk_egr_disabled: assert property (egr_req && !egr_on |=> egr_admit)
    else $error("egress limited while disabled");
  chk_full_rate: assert property (ing_req && ing_prio == 2'h0 && code0 == 7'h00 |=> ing_admit)
    else $error("code zero frame limited");
endmodule

bind rl_port_limiter rl_port_limiter_asserts rl_port_limiter_asserts_i (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ing_req(ing_req), .ing_prio(ing_prio),
  .ing_admit(ing_admit), .ing_hold(ing_hold), .ing_drop(ing_drop), .egr_req(egr_req),
  .egr_admit(egr_admit), .egr_hold(egr_hold), .egr_drop(egr_drop));

// ===== sim/rl_path_model.sv
// Frame path partner issuing ingress and egress requests
`timescale 1ns/1ns
module rl_path_model (
  // Clock
  input  wire        clk,
  // Ingress path
  output reg         ing_req,
  output reg  [10:0] ing_len,
  output reg  [1:0]  ing_prio,
  output reg  [1:0]  ing_kind,
  input  wire [2:0]  ing_ans,
  // Egress path
  output reg         egr_req,
  output reg  [10:0] egr_len,
  output reg  [1:0]  egr_prio,
  input  wire [2:0]  egr_ans
);
  initial begin
    {ing_req, ing_len, ing_prio, ing_kind} = 16'h0000;
    {egr_req, egr_len, egr_prio} = 14'h0000;
  end
  // Fields scrambled once the request drops
  task send(input logic egr, input logic [10:0] len, input logic [1:0] prio, input logic [1:0] kind,
            output logic [2:0] res);
    @(posedge clk);
    if (egr) {egr_req, egr_len, egr_prio} <= {1'b1, len, prio};
    else {ing_req, ing_len, ing_prio, ing_kind} <= {1'b1, len, prio, kind};
    @(posedge clk);
    {ing_req, egr_req} <= 2'h0;
    {ing_len, egr_len, ing_prio, egr_prio, ing_kind} <= ~{ing_len, egr_len, ing_prio, egr_prio, ing_kind};
    @(negedge clk);
    res = egr ? egr_ans : ing_ans;
  endtask
endmodule

// ===== sim/test_rl_port_limiter.sv
// Self-checking testbench of the port B rate limiter
`timescale 1ns/1ns
module test_rl_port_limiter;
  localparam logic [15:0] ADMIT = 16'h0001;
  localparam logic [15:0] HOLD  = 16'h0002;
  localparam logic [15:0] DROP  = 16'h0004;
  reg         clk;
  reg         rst_n;
  reg  [7:0]  reg_addr;
  reg  [15:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  reg         link_fast;
  wire [15:0] reg_rdata;
  wire        ing_req, egr_req, ing_admit, ing_hold, ing_drop, egr_admit, egr_hold, egr_drop;
  wire [10:0] ing_len, egr_len;
  wire [1:0]  ing_prio, ing_kind, egr_prio;
  integer     err_count;
  integer     total_checks;
  integer     m;
  integer     k;
  reg  [7:0]  rmap [0:4] = '{8'h8A, 8'h8C, 8'h8E, 8'h90, 8'h92};
  reg  [15:0] rmask [0:4] = '{16'h001F, 16'h7F7F, 16'h7F7F, 16'h7FFF, 16'h7F7F};

  rl_port_limiter rl_port_limiter_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_fast(link_fast), .ing_req(ing_req),
    .ing_len(ing_len), .ing_prio(ing_prio), .ing_kind(ing_kind), .ing_admit(ing_admit), .ing_hold(ing_hold),
    .ing_drop(ing_drop), .egr_req(egr_req), .egr_len(egr_len), .egr_prio(egr_prio), .egr_admit(egr_admit),
    .egr_hold(egr_hold), .egr_drop(egr_drop));
  rl_path_model rl_path_model_i (.clk(clk), .ing_req(ing_req), .ing_len(ing_len), .ing_prio(ing_prio),
    .ing_kind(ing_kind), .ing_ans({ing_drop, ing_hold, ing_admit}), .egr_req(egr_req), .egr_len(egr_len),
    .egr_prio(egr_prio), .egr_ans({egr_drop, egr_hold, egr_admit}));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
  endtask
  task reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    {reg_wdata, reg_wr} <= {~d, 1'b0};
    @(negedge clk);
  endtask
  task reg_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, exp);
  endtask
  // n admitted frames, then one frame with the given answer
  task frames(input logic e, input logic [1:0] p, input logic [1:0] kd, input logic [10:0] len,
              input integer n, input logic [15:0] last);
    integer i;
    logic [2:0] r;
    for (i = 0; i <= n; i = i + 1) begin
      rl_path_model_i.send(e, len, p, kd, r);
      check({13'h0000, r}, (i < n) ? ADMIT : last);
    end
  endtask
  task t_regs;
    integer i;
    for (i = 0; i < 5; i = i + 1) reg_chk(rmap[i], 16'h0000);
    for (i = 0; i < 5; i = i + 1) begin
      reg_write(rmap[i], 16'hFFFF);
      reg_chk(rmap[i], rmask[i]);
    end
    reg_write(8'h00, 16'hFFFF);
    reg_chk(8'h00, 16'h0000);
    do_reset;
  endtask
  task t_full;
    reg_write(8'h90, 16'h0080);
    frames(1'b0, 2'h0, 2'h3, 11'h7FF, 5, ADMIT);
    frames(1'b1, 2'h0, 2'h0, 11'h7FF, 5, ADMIT);
  endtask
  task t_gap_pre;
    reg_write(8'h8A, 16'h0002);
    reg_write(8'h8C, 16'h0100);
    frames(1'b0, 2'h1, 2'h0, 11'h3FB, 3, HOLD);
    frames(1'b0, 2'h0, 2'h0, 11'h7FF, 0, ADMIT);
    reg_write(8'h8A, 16'h0001);
    reg_write(8'h8E, 16'h0001);
    frames(1'b0, 2'h2, 2'h0, 11'h3FF, 3, HOLD);
    reg_write(8'hA0, 16'h0001);
    frames(1'b0, 2'h2, 2'h0, 11'h3FF, 0, DROP);
    reg_chk(8'hA2, 16'h0006);
    reg_chk(8'hA4, 16'h0003);
    reg_write(8'hA4, 16'h0000);
    reg_chk(8'hA4, 16'h0000);
  endtask
  task t_egr;
    do_reset;
    reg_write(8'h92, 16'h0100);
    frames(1'b1, 2'h3, 2'h0, 11'h7FF, 3, ADMIT);
    reg_write(8'h90, 16'h0080);
    reg_write(8'hA0, 16'h0002);
    frames(1'b1, 2'h3, 2'h0, 11'h7FF, 2, DROP);
    reg_chk(8'hA6, 16'h0001);
  endtask
  task t_mode;
    for (m = 0; m < 4; m = m + 1) begin
      do_reset;
      reg_write(8'h8A, {12'h000, m[1:0], 2'h0});
      reg_write(8'h8C, 16'h0001);
      for (k = 0; k < 4; k = k + 1) begin
        if (k < m) frames(1'b0, 2'h0, k[1:0], 11'h7FF, 2, ADMIT);
        else frames(1'b0, 2'h0, k[1:0], 11'h7FF, (k == m) ? 2 : 0, HOLD);
      end
    end
  endtask

  // Drain to 2 bytes, then refills of 100 bytes per period, period by link speed
  task t_refill;
    do_reset;
    reg_write(8'h8C, 16'h007F);
    frames(1'b0, 2'h0, 2'h0, 11'h7FF, 2, HOLD);
    repeat (1390) @(posedge clk);
    frames(1'b0, 2'h0, 2'h0, 11'h15E, 0, HOLD);
    repeat (398) @(posedge clk);
    frames(1'b0, 2'h0, 2'h0, 11'h15E, 0, ADMIT);
    @(posedge clk);
    link_fast <= 1'b0;
    do_reset;
    reg_write(8'h8C, 16'h007F);
    frames(1'b0, 2'h0, 2'h0, 11'h7FF, 2, HOLD);
    repeat (990) @(posedge clk);
    frames(1'b0, 2'h0, 2'h0, 11'h064, 0, HOLD);
    repeat (3198) @(posedge clk);
    frames(1'b0, 2'h0, 2'h0, 11'h064, 0, ADMIT);
  endtask

  initial begin
    {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd} = 27'h0000000;
    link_fast = 1'b1;
    err_count = 0;
    total_checks = 0;
    do_reset;
    t_regs;
    t_full;
    t_gap_pre;
    t_egr;
    t_mode;
    t_refill;
    test_done;
  end
  // Whole run needs about 6300 cycles
  initial begin
    #200000;
    err_count = err_count + 1;
    test_done;
  end
endmodule
